// ===== src/rvs_side_ports.sv
// Real-time vendor word port and slow-control bit port beside the framer
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rvs_defs.svh"

// Behaviour
// [R01] Each port exists only when its own enable option is set.
// [R02] Vendor word port exists only at the 10.1376 Gbps line rate.
// [R03] Both ports use valid/ready streaming; receive data one cycle late.
// [R04] Vendor words are 32 or 64 bits with 4 or 8 byte flags.
// [R05] All port signals run on the link-side clock only.
// [R06] Receive flag bit set for each byte holding a vendor byte.
// [R07] Accept high means a word is taken in the following cycle.
// [R08] Application raises qualifier exactly when the word is meaningful.
// [R09] Word inserted only after accept, with qualifier high now.
// [R10] Application times its transfers by the flags and accept.
// [R11] One shared write latency sets the accept-to-take delay.
// [R12] Slow-control port carries the extracted and inserted management bits.
// [R13] Receive presents one bit per cycle, valid when it holds HDLC.
// [R14] Slow-control accept means a bit is taken next cycle.
// [R15] HDLC layer raises valid only with a valid bit.
// [R16] Bit written into frame only after accept, with valid now.
// [R17] HDLC layer needs only the valid and accept flags for alignment.
// [R18] Unfilled slot gets default content; framer never stalls.
module rvs_side_ports import rvs_pkg::*; #(
  parameter int DW = `RVS_DW_DEF,
  parameter int WR_LAT = `RVS_WR_LAT_DEF,
  parameter int CW = `RVS_CNT_W_DEF,
  parameter int LINE_RATE_KBPS = `RVS_RTVS_RATE_KBPS,
  parameter bit EN_RTVS = 1'b1,
  parameter bit EN_HDLC = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RVS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DW-1:0] frm_rx_rtvs_word,
  input wire logic [DW/8-1:0] frm_rx_rtvs_lanes,
  input wire logic frm_rx_hdlc_bit,
  input wire logic frm_rx_hdlc_strobe,
  input wire logic frm_tx_rtvs_slot,
  output logic [DW-1:0] frm_tx_rtvs_word,
  output logic frm_tx_rtvs_fill,
  input wire logic frm_tx_hdlc_slot,
  output logic frm_tx_hdlc_bit,
  output logic frm_tx_hdlc_fill,
  output logic [DW/8-1:0] rt_vendor_rx_byte_flags,
  output logic [DW-1:0] rt_vendor_rx_word,
  output logic rt_vendor_tx_accept,
  input wire logic rt_vendor_tx_qualifier,
  input wire logic [DW-1:0] rt_vendor_tx_word,
  output logic slow_ctrl_rx_valid,
  output logic slow_ctrl_rx_bit,
  output logic slow_ctrl_tx_accept,
  input wire logic slow_ctrl_tx_valid,
  input wire logic slow_ctrl_tx_bit
);
  localparam int LN = DW / 8; // R04
  // Vendor accept, take qualifier and receive flags are held low unless both option and rate allow it
  localparam bit RTVS_ON = EN_RTVS && (LINE_RATE_KBPS == `RVS_RTVS_RATE_KBPS); // R01 R02

  typedef struct packed {
    logic rtvs_en;
    logic hdlc_en;
    logic [31:0] idle;
    logic [LN-1:0] rx_flags;
    logic [DW-1:0] rx_word;
    logic rx_bit_vld;
    logic rx_bit;
    logic [DW-1:0] tx_word;
    logic tx_fill;
    logic tx_bit;
    logic tx_bit_fill;
    logic [CW-1:0] miss_cnt;
    logic [CW-1:0] rtvs_cnt;
    logic [CW-1:0] hdlc_cnt;
    logic [31:0] rdata;
    logic rerr;
  } rvs_state_t;

  rvs_state_t q;
  rvs_state_t next_q;
  rvs_apb_phase_t phase;
  rvs_apb_word_t rd_val;
  logic rd_bad;
  logic [31:0] status;

  rvs_take_if rt_if ();
  rvs_take_if sc_if ();

  function automatic logic [CW-1:0] bump(input logic [CW-1:0] cnt);
    bump = CW'(cnt + 1'b1);
  endfunction : bump

  rvs_wlat #(.LAT(WR_LAT)) u_rt_lat (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .port(rt_if)
  );

  rvs_wlat #(.LAT(WR_LAT)) u_sc_lat (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .port(sc_if)
  );

  // Accept follows the framer's slot look-ahead, gated by the enables
  assign rt_vendor_tx_accept = RTVS_ON & q.rtvs_en & frm_tx_rtvs_slot; // R07
  assign slow_ctrl_tx_accept = EN_HDLC & q.hdlc_en & frm_tx_hdlc_slot; // R14
  assign rt_if.offer = rt_vendor_tx_accept;
  assign rt_if.valid = RTVS_ON & rt_vendor_tx_qualifier;
  assign sc_if.offer = slow_ctrl_tx_accept;
  assign sc_if.valid = EN_HDLC & slow_ctrl_tx_valid;

  assign status = (32'(LN) << `RVS_STAT_LANES_LSB)
    | (32'(WR_LAT) << `RVS_STAT_LAT_LSB)
    | (32'(EN_HDLC) << `RVS_STAT_HDLC_BIT)
    | (32'(RTVS_ON) << `RVS_STAT_RTVS_BIT);

  always_comb begin
    if (!psel) begin
      phase = RVS_PH_IDLE;
    end else if (!penable) begin
      phase = RVS_PH_SETUP;
    end else begin
      phase = RVS_PH_ACCESS;
    end
  end

  always_comb begin
    rd_val = 32'h0;
    rd_bad = 1'b0;
    unique case (paddr)
      `RVS_OFF_CTRL: begin
        rd_val[`RVS_CTRL_RTVS_BIT] = q.rtvs_en;
        rd_val[`RVS_CTRL_HDLC_BIT] = q.hdlc_en;
      end
      `RVS_OFF_STATUS: rd_val = status;
      `RVS_OFF_IDLE: rd_val = q.idle;
      `RVS_OFF_MISS: rd_val = 32'(q.miss_cnt);
      `RVS_OFF_RTVS_CNT: rd_val = 32'(q.rtvs_cnt);
      `RVS_OFF_HDLC_CNT: rd_val = 32'(q.hdlc_cnt);
      default: rd_bad = 1'b1;
    endcase
  end

  always_comb begin
    next_q = q;
    // Register bus; read data is caught in setup so the answer comes from flops
    unique case (phase)
      RVS_PH_SETUP: begin
        next_q.rdata = rd_val;
        next_q.rerr = rd_bad;
      end
      RVS_PH_ACCESS: begin
        if (pwrite && !rd_bad) begin
          unique case (paddr)
            `RVS_OFF_CTRL: begin
              next_q.rtvs_en = pwdata[`RVS_CTRL_RTVS_BIT]; // R01
              next_q.hdlc_en = pwdata[`RVS_CTRL_HDLC_BIT]; // R01
            end
            `RVS_OFF_IDLE: next_q.idle = pwdata;
            `RVS_OFF_MISS: next_q.miss_cnt = '0;
            `RVS_OFF_RTVS_CNT: next_q.rtvs_cnt = '0;
            `RVS_OFF_HDLC_CNT: next_q.hdlc_cnt = '0;
            default: next_q.idle = q.idle;
          endcase
        end
      end
      RVS_PH_IDLE: next_q.rerr = 1'b0;
      default: next_q.rerr = 1'b1;
    endcase

    // Receive side: one register stage gives the read latency of one
    next_q.rx_flags = (RTVS_ON && q.rtvs_en) ? frm_rx_rtvs_lanes : '0; // R03 R06
    if (|frm_rx_rtvs_lanes) begin
      next_q.rx_word = frm_rx_rtvs_word; // R06
    end
    next_q.rx_bit_vld = EN_HDLC & q.hdlc_en & frm_rx_hdlc_strobe; // R12 R13
    if (frm_rx_hdlc_strobe) begin
      next_q.rx_bit = frm_rx_hdlc_bit; // R13
    end

    // Transmit side; an empty slot carries idle content, framer never waits
    next_q.tx_fill = rt_if.take; // R09
    if (rt_if.take) begin
      next_q.tx_word = rt_vendor_tx_word; // R09
    end else begin
      next_q.tx_word = {(DW/32){q.idle}}; // R18
    end
    next_q.tx_bit_fill = sc_if.take; // R16
    if (sc_if.take) begin
      next_q.tx_bit = slow_ctrl_tx_bit; // R16
    end else begin
      next_q.tx_bit = `RVS_HDLC_IDLE_BIT; // R18
    end

    // Counters after the clears, so an event in a clear cycle survives
    if ((rt_if.due && !rt_if.valid) || (sc_if.due && !sc_if.valid)) begin
      next_q.miss_cnt = bump(next_q.miss_cnt); // R18
    end
    if (rt_if.take) begin
      next_q.rtvs_cnt = bump(next_q.rtvs_cnt);
    end
    if (sc_if.take) begin
      next_q.hdlc_cnt = bump(next_q.hdlc_cnt);
    end
  end

  // Single link-side clock for every port signal
  always_ff @(posedge sys_clk or negedge rst_n) begin // R05
    if (!rst_n) begin
      q <= '0;
      q.rtvs_en <= `RVS_CTRL_RST;
      q.hdlc_en <= `RVS_CTRL_RST;
      q.idle <= `RVS_IDLE_RST;
      q.tx_word <= '0;
      q.tx_bit <= `RVS_HDLC_IDLE_BIT;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & q.rerr;
  assign frm_tx_rtvs_word = q.tx_word;
  assign frm_tx_rtvs_fill = q.tx_fill;
  assign frm_tx_hdlc_bit = q.tx_bit;
  assign frm_tx_hdlc_fill = q.tx_bit_fill;
  assign rt_vendor_rx_byte_flags = q.rx_flags;
  assign rt_vendor_rx_word = q.rx_word;
  assign slow_ctrl_rx_valid = q.rx_bit_vld;
  assign slow_ctrl_rx_bit = q.rx_bit;

  a_rx_flags_lat: assert property ( // R06
    @(posedge sys_clk) disable iff (!rst_n)
    (RTVS_ON && q.rtvs_en && |frm_rx_rtvs_lanes) |=>
      rt_vendor_rx_byte_flags == $past(frm_rx_rtvs_lanes)
      && rt_vendor_rx_word == $past(frm_rx_rtvs_word))
    else $error("receive vendor word not presented one cycle later");

  a_rx_bit_lat: assert property ( // R13
    @(posedge sys_clk) disable iff (!rst_n)
    (EN_HDLC && q.hdlc_en && frm_rx_hdlc_strobe) |=>
      slow_ctrl_rx_valid && slow_ctrl_rx_bit == $past(frm_rx_hdlc_bit))
    else $error("receive slow-control bit not presented one cycle later");

  a_rx_bit_quiet: assert property ( // R03
    @(posedge sys_clk) disable iff (!rst_n)
    !frm_rx_hdlc_strobe |=> !slow_ctrl_rx_valid)
    else $error("slow-control valid without a framer strobe");

  a_rtvs_accept_gate: assert property ( // R07
    @(posedge sys_clk) disable iff (!rst_n)
    rt_vendor_tx_accept |-> frm_tx_rtvs_slot && q.rtvs_en)
    else $error("vendor accept raised without a slot");

  a_rtvs_absent: assert property ( // R02
    @(posedge sys_clk) disable iff (!rst_n)
    !RTVS_ON |-> !rt_vendor_tx_accept && rt_vendor_rx_byte_flags == '0)
    else $error("vendor port active where it does not exist");

  a_rtvs_insert: assert property ( // R09
    @(posedge sys_clk) disable iff (!rst_n)
    (rt_vendor_tx_accept ##WR_LAT rt_vendor_tx_qualifier) |=>
      frm_tx_rtvs_fill && frm_tx_rtvs_word == $past(rt_vendor_tx_word))
    else $error("accepted vendor word not inserted");

  a_rtvs_idle_fill: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_n)
    (rt_if.due && !rt_vendor_tx_qualifier) |=>
      !frm_tx_rtvs_fill && frm_tx_rtvs_word == {(DW/32){$past(q.idle)}})
    else $error("unfilled vendor slot lacks idle content");

  a_hdlc_accept_gate: assert property ( // R14
    @(posedge sys_clk) disable iff (!rst_n)
    slow_ctrl_tx_accept |-> frm_tx_hdlc_slot && q.hdlc_en)
    else $error("slow-control accept raised without a slot");

  a_hdlc_insert: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    frm_tx_hdlc_fill |->
      $past(sc_if.due) && $past(slow_ctrl_tx_valid)
      && frm_tx_hdlc_bit == $past(slow_ctrl_tx_bit))
    else $error("slow-control bit filled without accept and valid");

  a_miss_count: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_n)
    (rt_if.due && !rt_vendor_tx_qualifier && !(psel && penable && pwrite)) |=>
      q.miss_cnt == CW'($past(q.miss_cnt) + 1'b1))
    else $error("missed slot not counted");

  a_rtvs_fill_cause: assert property ( // R09
    @(posedge sys_clk) disable iff (!rst_n)
    frm_tx_rtvs_fill |-> $past(rt_if.due) && $past(rt_vendor_tx_qualifier))
    else $error("vendor word filled without accept and qualifier");

  a_rtvs_fill_quiet: assert property ( // R09
    @(posedge sys_clk) disable iff (!rst_n)
    !rt_if.due |=> !frm_tx_rtvs_fill)
    else $error("vendor fill outside a due slot");

  a_hdlc_take_lat: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    (slow_ctrl_tx_accept ##WR_LAT slow_ctrl_tx_valid) |=>
      frm_tx_hdlc_fill && frm_tx_hdlc_bit == $past(slow_ctrl_tx_bit))
    else $error("accepted slow-control bit not inserted");

  a_hdlc_idle_fill: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_n)
    (sc_if.due && !slow_ctrl_tx_valid) |=>
      !frm_tx_hdlc_fill && frm_tx_hdlc_bit == `RVS_HDLC_IDLE_BIT)
    else $error("unfilled slow-control slot lacks idle bit");

  a_hdlc_fill_quiet: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    !sc_if.due |=> !frm_tx_hdlc_fill)
    else $error("slow-control fill outside a due slot");

  a_rx_flags_off: assert property ( // R01
    @(posedge sys_clk) disable iff (!rst_n)
    !q.rtvs_en |=> rt_vendor_rx_byte_flags == '0)
    else $error("vendor receive flags raised while disabled");

  a_rx_bit_off: assert property ( // R01
    @(posedge sys_clk) disable iff (!rst_n)
    !q.hdlc_en |=> !slow_ctrl_rx_valid)
    else $error("slow-control receive valid raised while disabled");

  a_ctrl_write: assert property ( // R01
    @(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && pwrite && paddr == `RVS_OFF_CTRL) |=>
      q.rtvs_en == $past(pwdata[`RVS_CTRL_RTVS_BIT])
      && q.hdlc_en == $past(pwdata[`RVS_CTRL_HDLC_BIT]))
    else $error("enable write did not land");

  a_rtvs_count: assert property ( // R09
    @(posedge sys_clk) disable iff (!rst_n)
    (rt_if.take && !(psel && penable && pwrite)) |=>
      q.rtvs_cnt == CW'($past(q.rtvs_cnt) + 1'b1))
    else $error("inserted vendor word not counted");

  a_hdlc_count: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_n)
    (sc_if.take && !(psel && penable && pwrite)) |=>
      q.hdlc_cnt == CW'($past(q.hdlc_cnt) + 1'b1))
    else $error("inserted slow-control bit not counted");
endmodule : rvs_side_ports
`default_nettype wire

// ===== src/rvs_defs.svh
// Offsets, field positions, reset values and counts of the side-channel ports
`ifndef RVS_DEFS_SVH
`define RVS_DEFS_SVH

`define RVS_DW_DEF 32
`define RVS_WR_LAT_DEF 1
`define RVS_CNT_W_DEF 16
`define RVS_RTVS_RATE_KBPS 10137600
`define RVS_AW 8

`define RVS_OFF_CTRL 8'h00
`define RVS_OFF_STATUS 8'h04
`define RVS_OFF_IDLE 8'h08
`define RVS_OFF_MISS 8'h0c
`define RVS_OFF_RTVS_CNT 8'h10
`define RVS_OFF_HDLC_CNT 8'h14

`define RVS_CTRL_RTVS_BIT 0
`define RVS_CTRL_HDLC_BIT 1
`define RVS_CTRL_RST 1'b1
`define RVS_IDLE_RST 32'h0000_0000
`define RVS_HDLC_IDLE_BIT 1'b1

`define RVS_STAT_RTVS_BIT 0
`define RVS_STAT_HDLC_BIT 1
`define RVS_STAT_LAT_LSB 8
`define RVS_STAT_LANES_LSB 16

`endif

// ===== src/rvs_pkg.sv
// Shared types of the side-channel ports
`default_nettype none
package rvs_pkg;
  typedef logic [31:0] rvs_apb_word_t;
  typedef enum logic [1:0] {
    RVS_PH_IDLE = 2'b00,
    RVS_PH_SETUP = 2'b01,
    RVS_PH_ACCESS = 2'b10
  } rvs_apb_phase_t;
endpackage : rvs_pkg
`default_nettype wire

// ===== src/rvs_take_if.sv
// Offer, qualifier and take strobes between a port and its latency line
`timescale 1ns/10ps
`default_nettype none
interface rvs_take_if;
  logic offer;
  logic valid;
  logic due;
  logic take;
  modport frm (output offer, output valid, input due, input take);
  modport lat (input offer, input valid, output due, output take);
endinterface : rvs_take_if
`default_nettype wire

// ===== src/rvs_wlat.sv
// Write-latency line: turns an offered slot into a take strobe LAT cycles on
`timescale 1ns/10ps
`default_nettype none
`include "rvs_defs.svh"
module rvs_wlat import rvs_pkg::*; #(
  parameter int LAT = `RVS_WR_LAT_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  rvs_take_if.lat port
);
  typedef struct packed {
    logic [LAT-1:0] pipe;
  } rvs_wlat_state_t;

  rvs_wlat_state_t q;
  rvs_wlat_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.pipe = LAT'({q.pipe, port.offer}); // R11
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Only a slot offered exactly LAT cycles ago can be filled
  assign port.due = q.pipe[LAT-1];
  assign port.take = port.due & port.valid; // R09 R16

  a_take_cause: assert property ( // R11
    @(posedge sys_clk) disable iff (!rst_n)
    port.take |-> $past(port.offer, LAT) && port.valid)
    else $error("take without an offer LAT cycles before");

  a_offer_due: assert property ( // R09
    @(posedge sys_clk) disable iff (!rst_n)
    port.offer ##LAT port.valid |-> port.take)
    else $error("offered slot with valid data was not taken");
endmodule : rvs_wlat
`default_nettype wire

// ===== sim/rvs_app_model.sv
// Application and slow-control layer model on the transmit side
`timescale 1ns/10ps
`default_nettype none
module rvs_app_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic vend_accept,
  input wire logic ctrl_accept,
  input wire logic hold_off,
  input wire logic [31:0] vend_data,
  input wire logic ctrl_data,
  output logic vend_valid,
  output logic [31:0] vend_word,
  output logic ctrl_valid,
  output logic ctrl_bit
);
  // One-cycle write latency only; must match WR_LAT of the instance
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vend_valid <= 1'b0;
      vend_word <= 32'h0;
      ctrl_valid <= 1'b0;
      ctrl_bit <= 1'b0;
    end else begin
      vend_valid <= vend_accept && !hold_off;
      // Unqualified word toggles so stale data is never mistaken for valid
      vend_word <= (vend_accept && !hold_off) ? vend_data : ~vend_word;
      ctrl_valid <= ctrl_accept && !hold_off;
      ctrl_bit <= (ctrl_accept && !hold_off) ? ctrl_data : ~ctrl_bit;
    end
  end
endmodule : rvs_app_model
`default_nettype wire

// ===== sim/tb_rvs_side_ports.sv
// Testbench of the side-channel ports
`timescale 1ns/10ps
`default_nettype none
module tb_rvs_side_ports;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err;
  logic [31:0] rx_word = 32'h0, ftx_word, vrx_word, vtx_word;
  logic [3:0] rx_lanes = 4'h0, vrx_flags;
  logic hrx_bit = 1'b0, hrx_strobe = 1'b0, vslot = 1'b0, hslot = 1'b0;
  logic vfill, hbit, hfill, vacc, vqual, crx_valid, crx_bit, cacc, cvalid, cbit;
  logic hold_off = 1'b0;
  int num_errors = 0, n_compared = 0, cycles = 0;

  rvs_side_ports i_rvs_side_ports (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frm_rx_rtvs_word(rx_word),
    .frm_rx_rtvs_lanes(rx_lanes), .frm_rx_hdlc_bit(hrx_bit), .frm_rx_hdlc_strobe(hrx_strobe),
    .frm_tx_rtvs_slot(vslot), .frm_tx_rtvs_word(ftx_word), .frm_tx_rtvs_fill(vfill),
    .frm_tx_hdlc_slot(hslot), .frm_tx_hdlc_bit(hbit), .frm_tx_hdlc_fill(hfill),
    .rt_vendor_rx_byte_flags(vrx_flags), .rt_vendor_rx_word(vrx_word),
    .rt_vendor_tx_accept(vacc), .rt_vendor_tx_qualifier(vqual), .rt_vendor_tx_word(vtx_word),
    .slow_ctrl_rx_valid(crx_valid), .slow_ctrl_rx_bit(crx_bit), .slow_ctrl_tx_accept(cacc),
    .slow_ctrl_tx_valid(cvalid), .slow_ctrl_tx_bit(cbit));

  rvs_app_model i_rvs_app_model (.sys_clk(sys_clk), .rst_n(rst_n), .vend_accept(vacc),
    .ctrl_accept(cacc), .hold_off(hold_off), .vend_data(32'hc0de_1234), .ctrl_data(1'b0),
    .vend_valid(vqual), .vend_word(vtx_word), .ctrl_valid(cvalid), .ctrl_bit(cbit));

  always #4 sys_clk = ~sys_clk;

  // Whole run is about fifty cycles; ceiling of 5000 leaves ample margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_regs();
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0004_0103);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0004_0103);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk({q[30:0], err}, 32'h1);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_rx();
    @(posedge sys_clk);
    rx_lanes <= 4'h5;
    rx_word <= 32'h1122_3344;
    hrx_strobe <= 1'b1;
    hrx_bit <= 1'b1;
    @(posedge sys_clk);
    rx_lanes <= 4'h0;
    rx_word <= 32'heedd_ccbb;
    hrx_strobe <= 1'b0;
    hrx_bit <= 1'b0;
    #1;
    chk({28'h0, vrx_flags}, 32'h5);
    chk(vrx_word, 32'h1122_3344);
    chk({crx_valid, crx_bit}, 32'h3);
    @(posedge sys_clk);
    #1;
    chk({vrx_flags, crx_valid}, 32'h0);
    chk(vrx_word, 32'h1122_3344);
    $display("test_rx done");
  endtask : test_rx

  // Slot offered for one cycle; the model answers or holds off
  task automatic offer(input logic v, input logic h);
    @(posedge sys_clk);
    vslot <= v;
    hslot <= h;
    #1;
    chk({vacc, cacc}, {30'h0, v, h});
    @(posedge sys_clk);
    vslot <= 1'b0;
    hslot <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : offer

  task automatic test_tx();
    offer(1'b1, 1'b1);
    chk({vfill, hfill, hbit}, 32'h6);
    chk(ftx_word, 32'hc0de_1234);
    @(posedge sys_clk);
    #1;
    chk({vfill, hfill}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h1);
    $display("test_tx done");
  endtask : test_tx

  task automatic test_miss();
    apb(1'b1, 8'h08, 32'h5a5a_a5a5);
    apb(1'b1, 8'h0c, 32'h0);
    hold_off <= 1'b1;
    offer(1'b1, 1'b1);
    chk({vfill, hfill, hbit}, 32'h1);
    chk(ftx_word, 32'h5a5a_a5a5);
    hold_off <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h1);
    $display("test_miss done");
  endtask : test_miss

  task automatic test_disable();
    apb(1'b1, 8'h00, 32'h0);
    @(posedge sys_clk);
    vslot <= 1'b1;
    hslot <= 1'b1;
    rx_lanes <= 4'hf;
    hrx_strobe <= 1'b1;
    #1;
    chk({vacc, cacc}, 32'h0);
    @(posedge sys_clk);
    vslot <= 1'b0;
    hslot <= 1'b0;
    rx_lanes <= 4'h0;
    hrx_strobe <= 1'b0;
    #1;
    chk({vrx_flags, crx_valid}, 32'h0);
    chk({vfill, hfill}, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    $display("test_disable done");
  endtask : test_disable

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_regs();
    test_rx();
    test_tx();
    test_miss();
    test_disable();
    print_verdict();
  end
endmodule : tb_rvs_side_ports
`default_nettype wire
